//--- scp_pkg.sv
// What this block does
// - Activity flag reads 1 when either socket's video enable is set, else 0.
// - Standard video model flag is a constant 1; writes to it do nothing.
// - Read/write video enable turns this socket's video on or off; resets to 0.
// - Policy 0: clock stop permitted after 8 idle clocks and host clock-run preparing.
// - Policy 1: clock stop permitted after 8 idle clocks, host clock-run ignored.
// - Supply request bits 6:4: 000 off, 010 5V, 011 3.3V, 100 X.X, 101 Y.Y.
// - Program request bits 2:0: 000 off, 001 12V, 010 5V, 011 3.3V, 100, 101.
// - Bits 31:12, bit 8 and bit 3 read zero and ignore writes.
// - Voltage fields: global reset clears; bus reset clears only without power events.
// - Socket power other than 12V programming is applied only at a voltage the inserted card accepts.
package scp_pkg;

  localparam logic [7:0] SCP_CTRL_OFS  = 8'h10;
  localparam logic [7:0] SCP_STAT_OFS  = 8'h14;

  localparam int         SCP_ACT_BIT   = 11;
  localparam int         SCP_STD_BIT   = 10;
  localparam int         SCP_VEN_BIT   = 9;
  localparam int         SCP_STOP_BIT  = 7;
  localparam int         SCP_VCC_LSB   = 4;
  localparam int         SCP_VPP_LSB   = 0;
  localparam int         SCP_VW        = 3;

  localparam int         SCP_ST_PERMIT = 0;
  localparam int         SCP_ST_VPP    = 4;
  localparam int         SCP_ST_VCC    = 8;

  localparam logic [2:0] SCP_V_OFF     = 3'h0;
  localparam logic [2:0] SCP_VPP_12    = 3'h1;
  localparam logic [2:0] SCP_V_5       = 3'h2;
  localparam logic [2:0] SCP_V_33      = 3'h3;
  localparam logic [2:0] SCP_V_XX      = 3'h4;
  localparam logic [2:0] SCP_V_YY      = 3'h5;

  localparam logic [3:0] SCP_IDLE_CLKS = 4'h8;

  typedef enum logic [1:0] {
    SCP_CAP_5V,
    SCP_CAP_3V,
    SCP_CAP_XV,
    SCP_CAP_YV
  } scp_cap_t;

endpackage

//--- scp_sync.sv
`timescale 1ns/10ps
module scp_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } scp_sync_t;

  scp_sync_t st_r;
  scp_sync_t st_nxt;

  // Pins idle high, so both stages reset to ones to avoid a false reset pulse.
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{s1: '1, s2: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

//--- scp_clkrun.sv
`timescale 1ns/10ps
module scp_clkrun #(
  parameter logic [3:0] IDLE_CLKS = scp_pkg::SCP_IDLE_CLKS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic socket_idle,
  input  wire logic host_clkrun_preparing,
  input  wire logic clock_stop_policy,
  output logic      stop_permit
);

  typedef struct packed {
    logic [3:0] idle_cnt;
    logic       permit;
  } scp_clkrun_t;

  scp_clkrun_t st_r;
  scp_clkrun_t st_nxt;
  logic        idle_long;

  always_comb begin
    st_nxt    = st_r;
    idle_long = 1'b0;
    if (ce) begin
      if (!socket_idle) begin
        st_nxt.idle_cnt = 4'h0;
      end else if (st_r.idle_cnt < IDLE_CLKS) begin
        st_nxt.idle_cnt = st_r.idle_cnt + 4'h1;
      end
      idle_long     = socket_idle && (st_r.idle_cnt >= IDLE_CLKS);
      st_nxt.permit = idle_long && (clock_stop_policy || host_clkrun_preparing);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stop_permit = st_r.permit;

endmodule

//--- scp_socket_ctrl.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module scp_socket_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        global_reset_pin_n,
  input  wire logic        bus_reset_pin_n,
  input  wire logic        pme_enable,
  input  wire logic        card_present,
  input  wire logic [3:0]  card_voltage_ok,
  input  wire logic        other_video_port_enable,
  input  wire logic        socket_idle,
  input  wire logic        host_clkrun_preparing,
  output logic             video_port_enable,
  output logic             video_activity_any_socket,
  output logic             clock_stop_permit,
  output logic      [2:0]  vcc_apply,
  output logic      [2:0]  vpp_apply
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic        ven;
    logic        stop_policy;
    logic [2:0]  vcc_req;
    logic [2:0]  vpp_req;
    logic        activity;
    logic [2:0]  vcc_out;
    logic [2:0]  vpp_out;
    logic        permit;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } scp_state_t;

  scp_state_t st_r;
  scp_state_t st_nxt;

  logic [1:0]  pins_sync;
  logic        global_reset_pin_act;
  logic        bus_reset_pin_act;
  logic        permit_w;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic        setup_ph;
  logic        access_ph;
  logic        hit_ctrl;
  logic        hit_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pins and clock-run policy.

  // The reset pins come from outside the clock domain and are synchronised
  // first; a pulse shorter than one clock may be missed.
  scp_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({global_reset_pin_n, bus_reset_pin_n}),
    .q       (pins_sync)
  );

  assign global_reset_pin_act = !pins_sync[1];
  assign bus_reset_pin_act = !pins_sync[0];

  scp_clkrun #(
    .IDLE_CLKS (scp_pkg::SCP_IDLE_CLKS)
  ) u_clkrun (
    .pclk                  (pclk),
    .presetn               (presetn),
    .ce                    (ce),
    .socket_idle           (socket_idle),
    .host_clkrun_preparing (host_clkrun_preparing),
    .clock_stop_policy     (st_r.stop_policy),
    .stop_permit           (permit_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Voltage decoding.

  // Returns the code actually driven to the power switch. Anything the card
  // cannot take, or any reserved code, becomes power off.
  function automatic logic [2:0] scp_apply(input logic [2:0] code,
                                           input logic       is_vpp,
                                           input logic       present,
                                           input logic [3:0] ok);
    logic [2:0] res;
    res = scp_pkg::SCP_V_OFF;
    if (present) begin
      case (code)
        scp_pkg::SCP_VPP_12: res = is_vpp ? code : scp_pkg::SCP_V_OFF;
        scp_pkg::SCP_V_5:    res = ok[scp_pkg::SCP_CAP_5V] ? code : scp_pkg::SCP_V_OFF;
        scp_pkg::SCP_V_33:   res = ok[scp_pkg::SCP_CAP_3V] ? code : scp_pkg::SCP_V_OFF;
        scp_pkg::SCP_V_XX:   res = ok[scp_pkg::SCP_CAP_XV] ? code : scp_pkg::SCP_V_OFF;
        scp_pkg::SCP_V_YY:   res = ok[scp_pkg::SCP_CAP_YV] ? code : scp_pkg::SCP_V_OFF;
        default:             res = scp_pkg::SCP_V_OFF;
      endcase
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read views.

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[scp_pkg::SCP_ACT_BIT]  = st_r.activity;
    ctrl_word[scp_pkg::SCP_STD_BIT]  = 1'b1;
    ctrl_word[scp_pkg::SCP_VEN_BIT]  = st_r.ven;
    ctrl_word[scp_pkg::SCP_STOP_BIT] = st_r.stop_policy;
    ctrl_word[scp_pkg::SCP_VCC_LSB +: scp_pkg::SCP_VW] = st_r.vcc_req;
    ctrl_word[scp_pkg::SCP_VPP_LSB +: scp_pkg::SCP_VW] = st_r.vpp_req;
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[scp_pkg::SCP_ST_PERMIT] = st_r.permit;
    stat_word[scp_pkg::SCP_ST_VPP +: scp_pkg::SCP_VW] = st_r.vpp_out;
    stat_word[scp_pkg::SCP_ST_VCC +: scp_pkg::SCP_VW] = st_r.vcc_out;
  end

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable && st_r.ready;
  assign hit_ctrl  = (paddr == scp_pkg::SCP_CTRL_OFS);
  assign hit_stat  = (paddr == scp_pkg::SCP_STAT_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // The answer is prepared in the setup cycle so that pready, prdata and
      // pslverr all leave flip-flops and the access phase has no wait state.
      st_nxt.ready  = 1'b0;
      st_nxt.slverr = 1'b0;
      if (setup_ph) begin
        st_nxt.ready  = 1'b1;
        st_nxt.slverr = !(hit_ctrl || hit_stat) || (pwrite && hit_stat);
        st_nxt.rdata  = 32'h0000_0000;
        if (!pwrite && hit_ctrl) begin
          st_nxt.rdata = ctrl_word;
        end else if (!pwrite && hit_stat) begin
          st_nxt.rdata = stat_word;
        end
      end

      // Only the writable bits are taken; the rest of the word is dropped.
      if (access_ph && pwrite && hit_ctrl) begin
        if (pstrb[0]) begin
          st_nxt.stop_policy = pwdata[scp_pkg::SCP_STOP_BIT];
          st_nxt.vcc_req     = pwdata[scp_pkg::SCP_VCC_LSB +: scp_pkg::SCP_VW];
          st_nxt.vpp_req     = pwdata[scp_pkg::SCP_VPP_LSB +: scp_pkg::SCP_VW];
        end
        if (pstrb[1]) begin
          st_nxt.ven = pwdata[scp_pkg::SCP_VEN_BIT];
        end
      end

      // A reset pin wins over a write landing in the same cycle.
      if (global_reset_pin_act || bus_reset_pin_act) begin
        st_nxt.ven         = 1'b0;
        st_nxt.stop_policy = 1'b0;
      end
      // With power events enabled the card must keep power across a bus
      // reset, so only the global reset drops the requests.
      if (global_reset_pin_act || (bus_reset_pin_act && !pme_enable)) begin
        st_nxt.vcc_req = scp_pkg::SCP_V_OFF;
        st_nxt.vpp_req = scp_pkg::SCP_V_OFF;
      end

      st_nxt.activity = st_r.ven || other_video_port_enable;
      st_nxt.permit   = permit_w;
      st_nxt.vcc_out  = scp_apply(st_r.vcc_req, 1'b0, card_present, card_voltage_ok);
      st_nxt.vpp_out  = scp_apply(st_r.vpp_req, 1'b1, card_present, card_voltage_ok);
      // Programming voltage without supply voltage makes no sense for a card.
      if (st_nxt.vcc_out == scp_pkg::SCP_V_OFF) begin
        st_nxt.vpp_out = scp_pkg::SCP_V_OFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata                    = st_r.rdata;
  assign pready                    = st_r.ready;
  assign pslverr                   = st_r.slverr;
  assign video_port_enable         = st_r.ven;
  assign video_activity_any_socket = st_r.activity;
  assign clock_stop_permit         = st_r.permit;
  assign vcc_apply                 = st_r.vcc_out;
  assign vpp_apply                 = st_r.vpp_out;

endmodule

//--- scp_socket_ctrl_checker.sv
`timescale 1ns/10ps
module scp_socket_ctrl_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        other_video_port_enable,
  input wire logic        video_port_enable,
  input wire logic        video_activity_any_socket,
  input wire logic        card_present,
  input wire logic [3:0]  card_voltage_ok,
  input wire logic        socket_idle,
  input wire logic        clock_stop_permit,
  input wire logic [2:0]  vcc_apply,
  input wire logic [2:0]  vpp_apply
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] ok_q;
  logic       on_q;
  logic       rd;
  // The card view advances only with the block, so a frozen cycle compares like with like.
  always_ff @(posedge pclk) begin
    if (ce) begin
      ok_q <= card_voltage_ok;
      on_q <= card_present;
    end
  end
  assign rd = pready && !pwrite && paddr == scp_pkg::SCP_CTRL_OFS;
  sequence busy_run;
    (ce && !socket_idle)[*3];
  endsequence
  //////////////////////////////////////////////////
  activity_flag_a: assert property (ce |=>
    video_activity_any_socket == $past(video_port_enable | other_video_port_enable)) else $error("activity flag");
  model_flag_a: assert property (rd |-> prdata[10]) else $error("model flag");
  reserved_zero_a: assert property (rd |-> prdata[31:12] == 20'h0 && !prdata[8] && !prdata[3])
    else $error("reserved bits");
  stop_drop_a: assert property (busy_run |=> !clock_stop_permit) else $error("permit kept");
  stop_rise_a: assert property ($rose(clock_stop_permit) |-> $past(socket_idle, 2) && $past(socket_idle, 9))
    else $error("permit early");
  code_legal_a: assert property (vcc_apply != 3'h1 && vcc_apply < 3'h6 && vpp_apply < 3'h6)
    else $error("reserved code");
  vcc_safe_a: assert property (vcc_apply != 3'h0 |-> on_q && ok_q[vcc_apply[1:0] ^ 2'h2])
    else $error("bad supply");
  vpp_safe_a: assert property (vpp_apply != 3'h0 |->
    on_q && (vpp_apply == 3'h1 || ok_q[vpp_apply[1:0] ^ 2'h2])) else $error("bad program");
endmodule

//--- scp_card_model.sv
`timescale 1ns/10ps
module scp_card_model (
  input  wire logic       pclk,
  input  wire logic       insert,
  input  wire logic [3:0] caps,
  input  wire logic [2:0] vcc_apply,
  output logic            card_present,
  output logic      [3:0] card_voltage_ok,
  output logic            overvolt
);
  logic [3:0] ok_q       = 4'h0;
  logic       present_r  = 1'b0;
  logic       overvolt_r = 1'b0;
  assign card_present    = present_r;
  assign card_voltage_ok = present_r ? caps : 4'h0;
  assign overvolt        = overvolt_r;
  // The switch lags one edge, so a supply is judged against the card as it stood then.
  always @(posedge pclk) begin
    present_r <= insert;
    ok_q      <= card_voltage_ok;
    if (vcc_apply != 3'h0 && !(vcc_apply inside {[3'h2:3'h5]} && ok_q[vcc_apply[1:0] ^ 2'h2])) begin
      overvolt_r <= 1'b1;
    end
  end
endmodule

//--- tb.sv
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  pstrb = 4'hf;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        global_reset_pin_n = 1'b1;
  logic        bus_reset_pin_n = 1'b1;
  logic        pme_enable = 1'b0;
  logic        insert = 1'b0;
  logic [3:0]  caps = 4'h0;
  logic        card_present;
  logic [3:0]  card_voltage_ok;
  logic        other_video_port_enable = 1'b0;
  logic        socket_idle = 1'b0;
  logic        host_clkrun_preparing = 1'b0;
  logic        video_port_enable;
  logic        video_activity_any_socket;
  logic        clock_stop_permit;
  logic [2:0]  vcc_apply;
  logic [2:0]  vpp_apply;
  logic        overvolt;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [2:0]  p;
  logic [2:0]  v;
  int          errors = 0;
  int          samples_checked = 0;
  scp_socket_ctrl dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .global_reset_pin_n, .bus_reset_pin_n, .pme_enable, .card_present,
    .card_voltage_ok, .other_video_port_enable, .socket_idle, .host_clkrun_preparing, .video_port_enable,
    .video_activity_any_socket, .clock_stop_permit, .vcc_apply, .vpp_apply);
  scp_card_model card_u (.pclk, .insert, .caps, .vcc_apply, .card_present, .card_voltage_ok, .overvolt);
  always #25 pclk = ~pclk;
  //////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Each transfer opens one edge after the last ends, so no strobe is driven twice in a time step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic pulse(input logic glob);
    {global_reset_pin_n, bus_reset_pin_n} <= glob ? 2'b01 : 2'b10;
    tick(4);
    {global_reset_pin_n, bus_reset_pin_n} <= 2'b11;
    tick(4);
  endtask
  //////////////////////////////////////////////////
  initial begin
    tick(10);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'h400);
    chk(32'(rd_err), 32'h0);
    apb(1'b1, 8'h10, 32'hffffffff);
    tick(3);
    chk(32'(vcc_apply), 32'h0);
    chk(32'(video_port_enable), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'hef7);
    // Lane 0 alone must leave the video enable in lane 1 untouched.
    pstrb <= 4'h1;
    apb(1'b1, 8'h10, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'he00);
    apb(1'b1, 8'h10, 32'h0);
    tick(3);
    chk(32'(video_port_enable), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'h400);
    other_video_port_enable <= 1'b1;
    tick(3);
    chk(32'(video_activity_any_socket), 32'h1);
    other_video_port_enable <= 1'b0;
    insert <= 1'b1;
    caps   <= 4'hf;
    for (int i = 0; i < 8; i++) begin
      p = 3'(i - 1);
      v = (i > 1 && i < 6) ? 3'(i) : 3'h0;
      apb(1'b1, 8'h10, {25'h0, 3'(i), 1'b0, p});
      tick(3);
      chk(32'(vcc_apply), 32'(v));
      chk(32'(vpp_apply), v != 3'h0 ? 32'(p) : 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd_data, {20'h0, 4'h4, 1'b0, 3'(i), 1'b0, p});
    end
    caps <= 4'h1;
    apb(1'b1, 8'h10, 32'h32);
    tick(3);
    chk(32'(vcc_apply), 32'h0);
    apb(1'b1, 8'h10, 32'h26);
    tick(3);
    chk(32'({vcc_apply, vpp_apply}), 32'h10);
    apb(1'b1, 8'h10, 32'h23);
    tick(3);
    chk(32'({vcc_apply, vpp_apply}), 32'h10);
    apb(1'b1, 8'h10, 32'h22);
    tick(3);
    chk(32'({vcc_apply, vpp_apply}), 32'h12);
    insert <= 1'b0;
    tick(3);
    chk(32'({vcc_apply, vpp_apply}), 32'h0);
    insert <= 1'b1;
    pme_enable <= 1'b1;
    pulse(1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'h422);
    pme_enable <= 1'b0;
    pulse(1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'h400);
    apb(1'b1, 8'h10, 32'h22);
    pme_enable <= 1'b1;
    pulse(1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'h400);
    apb(1'b1, 8'h10, 32'h80);
    socket_idle <= 1'b1;
    tick(14);
    chk(32'(clock_stop_permit), 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    tick(3);
    chk(32'(clock_stop_permit), 32'h0);
    host_clkrun_preparing <= 1'b1;
    tick(3);
    chk(32'(clock_stop_permit), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd_data, 32'h1);
    chk(32'(rd_err), 32'h0);
    apb(1'b1, 8'h14, 32'hffffffff);
    chk(32'(rd_err), 32'h1);
    // With the clock enable low nothing may move, not even a permit whose cause has gone.
    ce <= 1'b0;
    host_clkrun_preparing <= 1'b0;
    tick(3);
    chk(32'(clock_stop_permit), 32'h1);
    ce <= 1'b1;
    tick(3);
    chk(32'(clock_stop_permit), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd_data[30:0], rd_err}, 32'h1);
    apb(1'b1, 8'h10, 32'h2a2);
    tick(3);
    chk(32'({vcc_apply, vpp_apply}), 32'h12);
    presetn <= 1'b0;
    tick(2);
    chk(32'({video_port_enable, clock_stop_permit, vcc_apply, vpp_apply}), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_data, 32'h400);
    chk(32'(overvolt), 32'h0);
    finish_test();
  end
endmodule
bind scp_socket_ctrl scp_socket_ctrl_checker chk_u (.pclk, .presetn, .ce, .pwrite, .paddr, .prdata, .pready,
  .other_video_port_enable, .video_port_enable, .video_activity_any_socket, .card_present, .card_voltage_ok,
  .socket_idle, .clock_stop_permit, .vcc_apply, .vpp_apply);
